/* verilog/i2cfe_map.svh */
`ifndef I2CFE_MAP_SVH
`define I2CFE_MAP_SVH
// ==========================================
// Array geometry
`define MEM_DEPTH 16384
`define ADDR_W 14
`define HI_ADDR_LSB 8
// ==========================================
// Serial framing
`define BITS_PER_BYTE 4'h8
`define BIT_CNT_ZERO 4'h0
`define BYTE_MSB 7
`define TYPE_MSB 7
`define TYPE_LSB 4
`define SEL_MSB 3
`define SEL_LSB 1
`define RW_BIT 0
// ==========================================
// Position of the byte just taken within a write transfer
`define BIDX_DEV 2'h0
`define BIDX_HI 2'h1
`define BIDX_LO 2'h2
`define BIDX_DATA 2'h3
`endif

/* verilog/fe_pkg.sv */
`include "i2cfe_map.svh"
package fe_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] sel_t;
   typedef logic [`ADDR_W-1:0] maddr_t;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_RX = 7'h04,
      ST_ACK_TX = 7'h08,
      ST_TX = 7'h10,
      ST_ACK_RX = 7'h20,
      ST_WAIT = 7'h40
   } state_t;
endpackage

/* verilog/mem_if.sv */
`timescale 1ns/10ps
`include "i2cfe_map.svh"
// Memory access request from the link domain and its crossing
interface mem_if;
   logic req;
   logic we;
   fe_pkg::maddr_t addr;
   fe_pkg::byte_t wdata;
   fe_pkg::byte_t rdata;
   logic busy;
   logic done;
   logic m_req;
   modport link(output req, we, addr, wdata, input busy, done, rdata);
   modport mem(input m_req, we, addr, wdata, output rdata);
   modport xfer(input req, output busy, done, m_req);
endinterface

/* verilog/bit_sync.sv */
`timescale 1ns/10ps
// Two flip-flop synchroniser, one per bit
module bit_sync #(
   parameter int W = 1
) (
   // Destination clock
   input wire logic clk,
   input wire logic rst,
   // Signals
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // bit_sync

/* verilog/hs_cross.sv */
`timescale 1ns/10ps
// Toggle handshake carrying one request at a time between the domains
module hs_cross (
   // Memory clock side
   input wire logic clk,
   input wire logic rst,
   // Link clock side
   input wire logic lclk,
   input wire logic lrst,
   // Request carrier
   mem_if.xfer x
);
   logic req_tgl_r;
   logic busy_r;
   logic ack_q_r;
   logic done_r;
   logic ack_tgl_r;
   logic req_q_r;
   logic ack_s;
   logic req_s;
   logic ack_edge;

   bit_sync #(.W(1)) u_ack_sync (.clk(lclk), .rst(lrst), .d(ack_tgl_r), .q(ack_s));
   bit_sync #(.W(1)) u_req_sync (.clk(clk), .rst(rst), .d(req_tgl_r), .q(req_s));

   assign ack_edge = ack_s ^ ack_q_r;

   // ==========================================
   // Link side: a request while busy is dropped
   always_ff @(posedge lclk or posedge lrst) begin
      if (lrst) begin
         req_tgl_r <= 1'h0;
         busy_r <= 1'h0;
         ack_q_r <= 1'h0;
         done_r <= 1'h0;
      end else begin
         ack_q_r <= ack_s;
         done_r <= ack_edge;
         if (x.req && !busy_r) begin
            req_tgl_r <= ~req_tgl_r;
         end
         if (ack_edge) begin
            busy_r <= 1'h0;
         end else if (x.req) begin
            busy_r <= 1'h1;
         end
      end
   end

   // ==========================================
   // Memory side: answer in the cycle after the request edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_q_r <= 1'h0;
         ack_tgl_r <= 1'h0;
      end else begin
         req_q_r <= req_s;
         if (x.m_req) begin
            ack_tgl_r <= ~ack_tgl_r;
         end
      end
   end

   assign x.m_req = req_s ^ req_q_r;
   assign x.busy = busy_r;
   assign x.done = done_r;
endmodule // hs_cross

/* verilog/i2c_slave_bus_front_end.sv */
`timescale 1ns/10ps
`include "i2cfe_map.svh"
// ==========================================
module i2c_slave_bus_front_end #(
   parameter logic [3:0] TYPE_CODE = 4'h5, // Arbitrary value
   parameter int DEPTH = `MEM_DEPTH
) (
   // Memory clock domain
   input wire logic CLOCK,
   input wire logic RESET,
   // Bus sampling clock
   input wire logic LINK_CLOCK,
   // Serial bus
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Straps
   input wire fe_pkg::sel_t DEVICE_SELECT_PINS,
   input wire logic WRITE_PROTECT,
   // Status, memory clock domain
   output logic ACTIVE
);
   import fe_pkg::*;

   function automatic maddr_t next_addr(input maddr_t a);
      next_addr = a + 1'h1;
   endfunction

   mem_if mif ();

   logic lrst_meta_r;
   logic lrst_r;
   logic scl_s;
   logic sda_s;
   sel_t sel_s;
   logic scl_q_r;
   logic sda_q_r;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   state_t st_r;
   logic [3:0] cnt_r;
   byte_t rx_sh_r;
   byte_t tx_sh_r;
   logic drive_r;
   logic rd_r;
   logic mack_r;
   logic [1:0] bidx_r;
   maddr_t addr_r;
   logic req_r;
   logic req_we_r;
   maddr_t req_addr_r;
   byte_t req_wdata_r;
   logic byte_end;
   logic addr_hit;
   logic ack_rise;
   logic rd_issue;
   logic wr_issue;
   logic tx_shift;
   logic ack_go;
   logic busy_l;
   logic wp_s;
   byte_t rdata_r;
   byte_t mem_r [DEPTH];

   // ==========================================
   // Link reset: asserted at once, released on the link clock
   always_ff @(posedge LINK_CLOCK or posedge RESET) begin
      if (RESET) begin
         lrst_meta_r <= 1'h1;
         lrst_r <= 1'h1;
      end else begin
         lrst_meta_r <= 1'h0;
         lrst_r <= lrst_meta_r;
      end
   end

   // ==========================================
   // Pin sampling; open pins arrive low thanks to board pull-downs
   bit_sync #(.W(5)) u_pin_sync (
      .clk(LINK_CLOCK),
      .rst(lrst_r),
      .d({SCL, SDA_IN, DEVICE_SELECT_PINS}),
      .q({scl_s, sda_s, sel_s})
   );

   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         scl_q_r <= 1'h0;
         sda_q_r <= 1'h0;
      end else begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   assign rise = scl_s && !scl_q_r;
   assign fall = !scl_s && scl_q_r;
   assign start = scl_s && scl_q_r && sda_q_r && !sda_s;
   assign stop = scl_s && scl_q_r && !sda_q_r && sda_s;

   assign byte_end = (cnt_r == `BITS_PER_BYTE);
   assign addr_hit = (rx_sh_r[`TYPE_MSB:`TYPE_LSB] == TYPE_CODE) &&
                     (rx_sh_r[`SEL_MSB:`SEL_LSB] == sel_s);
   assign ack_rise = rise && (st_r == ST_ACK_TX);
   // Write goes out only once its acknowledge is on the line, so a stop first drops it
   assign wr_issue = ack_rise && !rd_r && (bidx_r == `BIDX_DATA);
   assign rd_issue = (ack_rise && rd_r) || (rise && (st_r == ST_ACK_RX) && !sda_s);
   assign tx_shift = fall && (((st_r == ST_ACK_TX) && rd_r) ||
                              ((st_r == ST_TX) && !byte_end) ||
                              ((st_r == ST_ACK_RX) && mack_r));
   assign ack_go = fall && byte_end && (((st_r == ST_ADDR) && addr_hit) || (st_r == ST_RX));

   // ==========================================
   // Transfer state
   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         st_r <= ST_IDLE;
      end else if (stop) begin
         st_r <= ST_IDLE;
      end else if (start) begin
         st_r <= ST_ADDR;
      end else if (fall) begin
         case (st_r)
            ST_ADDR: begin
               if (byte_end) begin
                  st_r <= addr_hit ? ST_ACK_TX : ST_WAIT;
               end
            end
            ST_RX: begin
               if (byte_end) begin
                  st_r <= ST_ACK_TX;
               end
            end
            ST_ACK_TX: begin
               st_r <= rd_r ? ST_TX : ST_RX;
            end
            ST_TX: begin
               if (byte_end) begin
                  st_r <= ST_ACK_RX;
               end
            end
            ST_ACK_RX: begin
               st_r <= mack_r ? ST_TX : ST_WAIT;
            end
            default: begin
               st_r <= st_r;
            end
         endcase
      end
   end

   // ==========================================
   // Bit counter and shifters
   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         cnt_r <= `BIT_CNT_ZERO;
      end else if (start || (fall && ((st_r == ST_ACK_TX) || (st_r == ST_ACK_RX)))) begin
         cnt_r <= `BIT_CNT_ZERO;
      end else if (rise && ((st_r == ST_ADDR) || (st_r == ST_RX) || (st_r == ST_TX))) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         rx_sh_r <= 8'h00;
      end else if (rise && ((st_r == ST_ADDR) || (st_r == ST_RX))) begin
         rx_sh_r <= {rx_sh_r[`BYTE_MSB-1:0], sda_s};
      end
   end

   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         tx_sh_r <= 8'h00;
      end else if (mif.done && !req_we_r) begin
         tx_sh_r <= mif.rdata;
      end else if (tx_shift) begin
         tx_sh_r <= {tx_sh_r[`BYTE_MSB-1:0], 1'h0};
      end
   end

   // ==========================================
   // Data line drive: changes on a falling clock, or is released at once on a start or stop
   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         drive_r <= 1'h0;
      end else if (start || stop) begin
         drive_r <= 1'h0;
      end else if (fall) begin
         drive_r <= tx_shift ? ~tx_sh_r[`BYTE_MSB] : ack_go;
      end
   end

   assign SDA_OUT = 1'h0;
   assign SDA_OE = drive_r;

   // ==========================================
   // Direction, master acknowledge and byte position
   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         rd_r <= 1'h0;
      end else if (fall && (st_r == ST_ADDR) && byte_end && addr_hit) begin
         rd_r <= rx_sh_r[`RW_BIT];
      end
   end

   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         mack_r <= 1'h0;
      end else if (rise && (st_r == ST_ACK_RX)) begin
         mack_r <= !sda_s;
      end
   end

   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         bidx_r <= `BIDX_DEV;
      end else if (fall && (st_r == ST_ADDR) && byte_end) begin
         bidx_r <= `BIDX_DEV;
      end else if (ack_rise && !rd_r && (bidx_r != `BIDX_DATA)) begin
         bidx_r <= bidx_r + 2'h1;
      end
   end

   // ==========================================
   // Memory address pointer, kept across transfers for current-address reads
   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         addr_r <= '0;
      end else if (ack_rise && !rd_r && (bidx_r == `BIDX_HI)) begin
         // Upper bits of the high byte lie beyond the array and are ignored
         addr_r[`ADDR_W-1:`HI_ADDR_LSB] <= rx_sh_r[`ADDR_W-1-`HI_ADDR_LSB:0];
      end else if (ack_rise && !rd_r && (bidx_r == `BIDX_LO)) begin
         addr_r[`HI_ADDR_LSB-1:0] <= rx_sh_r;
      end else if (wr_issue) begin
         addr_r <= next_addr(addr_r);
      end else if (mif.done && !req_we_r) begin
         addr_r <= next_addr(addr_r);
      end
   end

   // ==========================================
   // Requests to the memory domain; held stable until answered
   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         req_r <= 1'h0;
      end else begin
         req_r <= rd_issue || wr_issue;
      end
   end

   always_ff @(posedge LINK_CLOCK or posedge lrst_r) begin
      if (lrst_r) begin
         req_we_r <= 1'h0;
         req_addr_r <= '0;
         req_wdata_r <= 8'h00;
      end else if ((rd_issue || wr_issue) && !mif.busy) begin
         req_we_r <= wr_issue;
         req_addr_r <= addr_r;
         req_wdata_r <= rx_sh_r;
      end
   end

   assign mif.req = req_r;
   assign mif.we = req_we_r;
   assign mif.addr = req_addr_r;
   assign mif.wdata = req_wdata_r;

   hs_cross u_cross (
      .clk(CLOCK),
      .rst(RESET),
      .lclk(LINK_CLOCK),
      .lrst(lrst_r),
      .x(mif)
   );

   // ==========================================
   // Array in the memory domain; protect pin sampled here, open pin reads low
   bit_sync #(.W(1)) u_wp_sync (.clk(CLOCK), .rst(RESET), .d(WRITE_PROTECT), .q(wp_s));

   // Storage has no reset: contents are data, not control
   always_ff @(posedge CLOCK) begin
      if (mif.m_req && mif.we && !wp_s) begin
         mem_r[mif.addr] <= mif.wdata;
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         rdata_r <= 8'h00;
      end else if (mif.m_req) begin
         rdata_r <= mem_r[mif.addr];
      end
   end

   assign mif.rdata = rdata_r;

   assign busy_l = (st_r != ST_IDLE);
   bit_sync #(.W(1)) u_act_sync (.clk(CLOCK), .rst(RESET), .d(busy_l), .q(ACTIVE));

   // ==========================================
   // Checks
   sequence s_byte_in;
      (st_r == ST_RX) && fall && byte_end;
   endsequence

   sequence s_nack_fall;
      (st_r == ST_ACK_RX) && fall && !mack_r && !start && !stop;
   endsequence

   sequence s_bad_addr;
      (st_r == ST_ADDR) && fall && byte_end && !addr_hit && !start && !stop;
   endsequence

   a_drive_low_only: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      SDA_OE |-> (SDA_OUT == 1'h0)) else $error("Data line driven high");

   a_start_enters: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      start |=> (st_r == ST_ADDR) && (cnt_r == `BIT_CNT_ZERO) && !SDA_OE)
      else $error("Start not taken");

   a_stop_standby: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      stop |=> (st_r == ST_IDLE) && !SDA_OE) else $error("Stop did not end transfer");

   a_data_ack: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      s_byte_in |=> SDA_OE && (st_r == ST_ACK_TX)) else $error("Received byte not acknowledged");

   a_bad_addr_quiet: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      s_bad_addr |=> ((st_r == ST_WAIT) && !SDA_OE) [*2]) else $error("Answered foreign address");

   a_nack_release: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      s_nack_fall |=> (st_r == ST_WAIT) && !SDA_OE) else $error("Bus held after not-acknowledge");

   a_ack_slot_free: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      (st_r == ST_ACK_RX) |-> !SDA_OE) else $error("Line held in master acknowledge slot");

   a_drive_scl_low: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      ($changed(SDA_OE) && !$past(start) && !$past(stop)) |-> !scl_q_r)
      else $error("Data changed with clock high");

   a_read_next: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      (rise && (st_r == ST_ACK_RX) && !sda_s) |=> req_r ##1 !req_we_r)
      else $error("No read after master acknowledge");

   a_write_issue: assert property (@(posedge LINK_CLOCK) disable iff (lrst_r)
      wr_issue |=> req_r ##1 (req_we_r && (req_wdata_r == $past(rx_sh_r, 2))))
      else $error("Write not passed on");
endmodule // i2c_slave_bus_front_end

/* dv/i2c_master_model.sv */
`timescale 1ns/10ps
// ==========================================
// Bus master model: owns the clock, pulls data low or lets the pull-up win
module i2c_master_model
   import fe_pkg::*;
(
   // Timing reference
   input wire logic clk,
   // Bus
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Quarter bit is 100 ns, which leaves the read prefetch its margin
   task automatic q_wait();
      repeat (25) @(posedge clk);
      #1;
   endtask
   task automatic bit_x(input logic b, output logic s);
      q_wait();
      sda_low = !b;
      q_wait();
      scl = 1'b1;
      q_wait();
      s = sda;
      q_wait();
      scl = 1'b0;
   endtask
   task automatic start();
      q_wait();
      sda_low = 1'b0;
      q_wait();
      scl = 1'b1;
      q_wait();
      sda_low = 1'b1;
      q_wait();
      scl = 1'b0;
   endtask
   task automatic stop();
      q_wait();
      sda_low = 1'b1;
      q_wait();
      scl = 1'b1;
      q_wait();
      sda_low = 1'b0;
      q_wait();
   endtask
   task automatic wr_byte(input byte_t d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], s);
      end
      bit_x(1'b1, s);
      ack = !s;
   endtask
   task automatic rd_byte(input logic nack, output byte_t d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, d[i]);
      end
      bit_x(nack, s);
   endtask
endmodule // i2c_master_model

/* dv/i2c_slave_bus_front_end_test.sv */
`timescale 1ns/10ps
module i2c_slave_bus_front_end_test;
   import fe_pkg::*;
   localparam logic [3:0] TC = 4'h9; // Arbitrary type code
   typedef struct {sel_t pins; byte_t word; logic ack;} row_t;
   logic clock, reset, link_clock, wp, scl, sda_low, sda, sda_out, sda_oe, active, s;
   sel_t sel;
   byte_t d;
   int err_total, checks, cyc;
   row_t rows[8];
   // Open-drain wire with pull-up
   assign sda = !(sda_oe | sda_low);
   i2c_slave_bus_front_end #(.TYPE_CODE(TC)) u_dut (.CLOCK(clock), .RESET(reset), .LINK_CLOCK(link_clock),
      .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .DEVICE_SELECT_PINS(sel),
      .WRITE_PROTECT(wp), .ACTIVE(active));
   i2c_master_model u_m (.clk(clock), .scl(scl), .sda_low(sda_low), .sda(sda));
   // ==========================================
   // Clocks and timeout
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      link_clock = 1'b0;
      #3.3;
      forever #7.5 link_clock = ~link_clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         end_sim();
      end
   end
   // ==========================================
   // Helpers
   task automatic end_sim();
      if (err_total == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   task automatic wb(byte_t b, logic e);
      u_m.wr_byte(b, s);
      chk("ack", {7'h00, e}, {7'h00, s});
   endtask
   task automatic idle_chk();
      u_m.stop();
      repeat (20) @(posedge clock);
      chk("active", 8'h00, {7'h00, active});
   endtask
   task automatic set_ptr(byte_t hi, byte_t lo);
      u_m.start();
      wb({TC, 3'h5, 1'b0}, 1'b1);
      wb(hi, 1'b1);
      wb(lo, 1'b1);
   endtask
   task automatic write_at(byte_t hi, byte_t lo, byte_t v);
      set_ptr(hi, lo);
      wb(v, 1'b1);
      idle_chk();
   endtask
   task automatic read_at(byte_t hi, byte_t lo, byte_t e);
      set_ptr(hi, lo);
      u_m.start();
      wb({TC, 3'h5, 1'b1}, 1'b1);
      u_m.rd_byte(1'b1, d);
      chk("rdata", e, d);
      repeat (30) @(posedge clock);
      chk("released", 8'h00, {7'h00, sda_oe});
      idle_chk();
   endtask
   // ==========================================
   // Main sequence
   initial begin
      reset = 1'b1;
      wp = 1'b0;
      sel = 3'h0;
      rows = '{'{3'h0, {TC, 3'h0, 1'b0}, 1'b1}, '{3'h5, {TC, 3'h5, 1'b0}, 1'b1},
         '{3'h7, {TC, 3'h7, 1'b1}, 1'b1}, '{3'h5, {TC, 3'h4, 1'b0}, 1'b0},
         '{3'h5, {TC, 3'h1, 1'b0}, 1'b0}, '{3'h3, {TC, 3'h6, 1'b0}, 1'b0},
         '{3'h2, {~TC, 3'h2, 1'b0}, 1'b0}, '{3'h6, {TC, 3'h6, 1'b1}, 1'b1}};
      repeat (8) @(posedge clock);
      chk("oe_rst", 8'h00, {7'h00, sda_oe});
      chk("active_rst", 8'h00, {7'h00, active});
      #1;
      reset = 1'b0;
      repeat (20) @(posedge clock);
      foreach (rows[i]) begin
         sel = rows[i].pins;
         u_m.start();
         wb(rows[i].word, rows[i].ack);
         chk("sda_out", 8'h00, {7'h00, sda_out});
         repeat (20) @(posedge clock);
         chk("active", 8'h01, {7'h00, active});
         if (rows[i].ack && rows[i].word[0]) begin
            u_m.rd_byte(1'b1, d);
         end
         idle_chk();
      end
      sel = 3'h5;
      // Back-to-back bytes, then a repeated start read of both
      set_ptr(8'h01, 8'h23);
      wb(8'ha5, 1'b1);
      wb(8'h3c, 1'b1);
      idle_chk();
      set_ptr(8'h01, 8'h23);
      u_m.start();
      wb({TC, 3'h5, 1'b1}, 1'b1);
      u_m.rd_byte(1'b0, d);
      chk("rd0", 8'ha5, d);
      u_m.rd_byte(1'b1, d);
      chk("rd1", 8'h3c, d);
      idle_chk();
      // Protected write is taken but not stored
      wp = 1'b1;
      write_at(8'h01, 8'h23, 8'h77);
      read_at(8'h01, 8'h23, 8'ha5);
      wp = 1'b0;
      // Upper two address bits are ignored
      write_at(8'hc1, 8'h23, 8'h5a);
      read_at(8'h01, 8'h23, 8'h5a);
      // Stop in mid data byte drops it
      set_ptr(8'h01, 8'h23);
      for (int i = 0; i < 4; i++) begin
         u_m.bit_x(1'b0, s);
      end
      idle_chk();
      read_at(8'h01, 8'h23, 8'h5a);
      // Reset in mid address word
      u_m.start();
      for (int i = 0; i < 4; i++) begin
         u_m.bit_x(1'b1, s);
      end
      @(posedge clock);
      #1;
      reset = 1'b1;
      repeat (8) @(posedge clock);
      chk("oe_rst2", 8'h00, {7'h00, sda_oe});
      chk("active_rst2", 8'h00, {7'h00, active});
      #1;
      reset = 1'b0;
      repeat (20) @(posedge clock);
      u_m.stop();
      read_at(8'h01, 8'h23, 8'h5a);
      end_sim();
   end
endmodule // i2c_slave_bus_front_end_test
